// *** hdl/ebd_pkg.sv ***
// constants and types shared by the emulator bus debug control block
`default_nettype none
package ebd_pkg;
   // address and chip select register geometry
   localparam int ADDR_W = 24;
   localparam int CS_REG_W = 16;
   localparam int CS_DEFAULT_N = 4;
   // base register: enable bit and base address field (compared to addr[23:11])
   localparam int BASE_EN_BIT = 0;
   localparam int BASE_ADDR_LSB = 1;
   localparam int BASE_ADDR_W = 13;
   localparam int CMP_ADDR_LSB = 11;
   // option register: block-size mask field and acknowledge-source bit
   localparam int MASK_LSB = 1;
   localparam int ACK_SRC_BIT = 14;
   // reset value of a chip select register image
   localparam logic [CS_REG_W-1:0] CS_REG_RESET = 16'h0000;
   // software-breakpoint trap number and the vector it selects
   localparam int TRAP_NUM_W = 4;
   localparam logic [TRAP_NUM_W-1:0] TRAP_NUM_RESET = 4'h0;
   localparam logic [7:0] TRAP_VEC_BASE = 8'h20;
   // trace qualification encodings
   typedef enum logic [1:0] {
      EBD_TRQ_BACKGROUND = 2'h0,
      EBD_TRQ_BOTH = 2'h1,
      EBD_TRQ_FOREGROUND = 2'h2
   } ebd_trq_type;
   // emulator-terminated access: time and derived clock count
   localparam int CLK_PERIOD_NS = 40;
   localparam int EMU_ACK_DELAY_NS = 80;
   localparam int EMU_ACK_CYCLES_RAW = (EMU_ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EMU_ACK_CYCLES = (EMU_ACK_CYCLES_RAW < 1) ? 1 : EMU_ACK_CYCLES_RAW;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
   // bus cycle sequencer states
   typedef enum logic [2:0] {
      EBD_IDLE = 3'b001,
      EBD_WAIT = 3'b010,
      EBD_DONE = 3'b100
   } ebd_state_type;
endpackage
`default_nettype wire

// *** hdl/ebd_control.sv ***
// bus cycle acknowledge, rom guard, breakpoint trap and trace qualification logic
// Function
// - background monitor without driven cycles keeps tgt_cycle_valid low; an internal select still drives the target acknowledge.
// - each chip select acknowledges internally or from an external acknowledge.
// - acknowledge source of an active chip select comes from its option register.
// - internal select drives acknowledge to target, none to processor.
// - external select acknowledges processor from emulator or target.
// - rom-write break enabled: user write to rom region breaks to monitor.
// - writes to emulation rom are suppressed; target ram mapped rom is not.
// - rom-write break disabled: no break, emulation rom still unmodified.
// - breakpoint trap number is 0 to 15 and selects the exception vector.
// - changing the trap number disables all defined software breakpoints.
// - trace records background only, both, or foreground only.
// - interlock holds visible emulation accesses for target acknowledge; otherwise emulator ends them.
`default_nettype none
module ebd_control #(
   parameter int CS_N = ebd_pkg::CS_DEFAULT_N
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // configuration
   input wire logic drive_bg_cycles,
   input wire logic interlock_en,
   input wire logic rom_break_en,
   input wire logic [CS_N-1:0] cs_src_cfg_internal,
   input wire logic [ebd_pkg::TRAP_NUM_W-1:0] trap_num_cfg,
   input wire logic sw_bkpt_arm,
   input wire logic [1:0] trace_qual,
   // chip select register images
   input wire logic [CS_N*ebd_pkg::CS_REG_W-1:0] chip_select_base_regs,
   input wire logic [CS_N*ebd_pkg::CS_REG_W-1:0] chip_select_option_regs,
   // processor bus cycle
   input wire logic cpu_strobe,
   input wire logic [ebd_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic cpu_write,
   input wire logic in_background,
   input wire logic map_rom,
   input wire logic map_emul,
   output logic cpu_transfer_ack_n,
   // target bus
   input wire logic transfer_ack_n_in,
   output logic transfer_ack_n_out,
   output logic transfer_ack_oe_n,
   output logic tgt_cycle_valid,
   // emulation memory and debug
   output logic emem_write_en,
   output logic break_req,
   output logic sw_bkpt_enable,
   output logic [7:0] sw_bkpt_vector,
   output logic trace_record,
   output logic cs_src_mismatch
);
   import ebd_pkg::*;

   // the packed register images and the decode are laid out for one to eight selects
   if (CS_N < 1 || CS_N > 8) begin : g_bad_cs_n
      $error("CS_N must be between 1 and 8");
   end

   // chip select decode, one slice per select
   logic [CS_N-1:0] cs_hit;
   logic [CS_N-1:0] cs_int;
   genvar g;
   generate
      for (g = 0; g < CS_N; g++) begin : g_cs
         logic [CS_REG_W-1:0] base;
         logic [CS_REG_W-1:0] opt;
         logic [BASE_ADDR_W-1:0] diff;
         assign base = chip_select_base_regs[g*CS_REG_W +: CS_REG_W];
         assign opt = chip_select_option_regs[g*CS_REG_W +: CS_REG_W];
         // masked address against base; one contiguous block assumed
         assign diff = (cpu_addr[CMP_ADDR_LSB +: BASE_ADDR_W] ^ base[BASE_ADDR_LSB +: BASE_ADDR_W])
                       & opt[MASK_LSB +: BASE_ADDR_W];
         assign cs_hit[g] = base[BASE_EN_BIT] && (diff == '0);
         assign cs_int[g] = cs_hit[g] && opt[ACK_SRC_BIT];
      end
   endgenerate

   logic cs_int_hit;
   logic trace_hit;
   assign cs_int_hit = |cs_int;
   // configured source disagreeing with the option register of a hit select is flagged
   assign cs_src_mismatch = |(cs_hit & (cs_int ^ (cs_hit & cs_src_cfg_internal)));

   always_comb begin
      case (trace_qual)
         EBD_TRQ_BACKGROUND: trace_hit = in_background;
         EBD_TRQ_FOREGROUND: trace_hit = !in_background;
         default: trace_hit = 1'b1;
      endcase
   end

   // bus cycle sequencer
   ebd_state_type state;
   ebd_state_type next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic ack_int;
   logic next_ack_int;
   logic tgt_vis;
   logic next_tgt_vis;
   logic wait_tgt;
   logic next_wait_tgt;
   logic emem_we;
   logic next_emem_we;
   logic next_break_req;
   logic next_trace_record;
   logic vis_now;

   assign vis_now = !in_background || drive_bg_cycles;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_ack_int = ack_int;
      next_tgt_vis = tgt_vis;
      next_wait_tgt = wait_tgt;
      next_emem_we = emem_we;
      next_break_req = 1'b0;
      next_trace_record = 1'b0;
      case (state)
         EBD_IDLE: begin
            if (cpu_strobe) begin
               next_tgt_vis = vis_now;
               next_ack_int = cs_int_hit;
               next_emem_we = cpu_write && !(map_emul && map_rom);
               next_break_req = cpu_write && map_rom && rom_break_en && !in_background;
               next_trace_record = trace_hit;
               // target answers visible cycles unless emulation memory runs without interlock
               next_wait_tgt = vis_now && (!map_emul || interlock_en);
               next_cnt = CNT_W'(EMU_ACK_CYCLES - 1);
               if (cs_int_hit) begin
                  next_state = EBD_DONE;
               end else begin
                  next_state = EBD_WAIT;
               end
            end
         end
         EBD_WAIT: begin
            if (!cpu_strobe) begin
               next_state = EBD_IDLE;
            end else if (wait_tgt) begin
               if (!transfer_ack_n_in) begin
                  next_state = EBD_DONE;
               end
            end else if (cnt == '0) begin
               next_state = EBD_DONE;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         EBD_DONE: begin
            if (!cpu_strobe) begin
               next_state = EBD_IDLE;
            end
         end
         default: next_state = EBD_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= EBD_IDLE;
         cnt <= CNT_RESET;
         ack_int <= 1'b0;
         tgt_vis <= 1'b0;
         wait_tgt <= 1'b0;
         emem_we <= 1'b0;
         break_req <= 1'b0;
         trace_record <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         ack_int <= next_ack_int;
         tgt_vis <= next_tgt_vis;
         wait_tgt <= next_wait_tgt;
         emem_we <= next_emem_we;
         break_req <= next_break_req;
         trace_record <= next_trace_record;
      end
   end

   logic busy;
   assign busy = (state != EBD_IDLE);
   assign cpu_transfer_ack_n = !(state == EBD_DONE && !ack_int);
   assign transfer_ack_oe_n = !(state == EBD_DONE && ack_int);
   assign transfer_ack_n_out = 1'b0;
   assign tgt_cycle_valid = busy && tgt_vis;
   assign emem_write_en = busy && emem_we;

   // software breakpoint trap number
   logic [TRAP_NUM_W-1:0] trap_num;
   logic [TRAP_NUM_W-1:0] next_trap_num;
   logic next_sw_bkpt_enable;
   logic [7:0] next_sw_bkpt_vector;

   always_comb begin
      next_trap_num = trap_num_cfg;
      next_sw_bkpt_vector = TRAP_VEC_BASE + {4'h0, trap_num_cfg};
      if (trap_num_cfg != trap_num) begin
         next_sw_bkpt_enable = 1'b0;
      end else if (sw_bkpt_arm) begin
         next_sw_bkpt_enable = 1'b1;
      end else begin
         next_sw_bkpt_enable = sw_bkpt_enable;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trap_num <= TRAP_NUM_RESET;
         sw_bkpt_enable <= 1'b0;
         sw_bkpt_vector <= TRAP_VEC_BASE;
      end else begin
         trap_num <= next_trap_num;
         sw_bkpt_enable <= next_sw_bkpt_enable;
         sw_bkpt_vector <= next_sw_bkpt_vector;
      end
   end

   // checks
   bg_bus_idle_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && in_background && !drive_bg_cycles)
      |=> !tgt_cycle_valid throughout (busy [*1]))
      else $error("target saw a cycle during undriven background");

   int_no_cpu_ack_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && cs_int_hit)
      |=> (!transfer_ack_oe_n && cpu_transfer_ack_n))
      else $error("internal select acked processor or did not drive target");

   ext_cpu_ack_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && !cs_int_hit && !vis_now)
      ##1 cpu_strobe [*2] |=> !cpu_transfer_ack_n)
      else $error("emulator did not acknowledge external select in time");

   interlock_wait_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_WAIT && wait_tgt && transfer_ack_n_in) |=> cpu_transfer_ack_n)
      else $error("acknowledge given before the target answered");

   rom_break_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && cpu_write && map_rom && rom_break_en && !in_background)
      |=> break_req ##1 !break_req)
      else $error("rom write did not raise a single break pulse");

   rom_no_break_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && !rom_break_en) |=> !break_req)
      else $error("break raised while rom breaks disabled");

   emem_rom_guard_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && map_emul && map_rom)
      |=> !emem_write_en [*2])
      else $error("emulation rom written");

   trap_change_a: assert property (@(posedge clk) disable iff (!rstn)
      (trap_num_cfg != trap_num) |=> (!sw_bkpt_enable
      && sw_bkpt_vector == TRAP_VEC_BASE + {4'h0, $past(trap_num_cfg)}))
      else $error("trap change left breakpoints enabled");

   trace_fg_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && trace_qual == EBD_TRQ_FOREGROUND && in_background)
      |=> !trace_record)
      else $error("background cycle traced in foreground-only mode");

   trace_bg_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && trace_qual == EBD_TRQ_BACKGROUND && !in_background)
      |=> !trace_record)
      else $error("foreground cycle traced in background-only mode");

   trace_both_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && trace_qual == EBD_TRQ_BOTH)
      |=> trace_record)
      else $error("cycle not traced in both mode");

   tgt_wait_ack_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_WAIT && wait_tgt && cpu_strobe && !transfer_ack_n_in)
      |=> !cpu_transfer_ack_n)
      else $error("target acknowledge not passed to the processor");

   ext_ack_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_DONE && !ack_int && cpu_strobe)
      |=> !cpu_transfer_ack_n)
      else $error("processor acknowledge dropped before the strobe");

   ext_no_drive_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && !cs_int_hit)
      |=> transfer_ack_oe_n)
      else $error("external select drove the target acknowledge");

   fg_visible_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && !in_background)
      |=> tgt_cycle_valid)
      else $error("foreground cycle hidden from the target");

   tgt_ram_write_a: assert property (@(posedge clk) disable iff (!rstn)
      (state == EBD_IDLE && cpu_strobe && cpu_write && map_rom && !map_emul)
      |=> emem_write_en)
      else $error("write to target memory mapped as rom suppressed");

   trap_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      (trap_num_cfg == trap_num && !sw_bkpt_arm)
      |=> $stable(sw_bkpt_enable))
      else $error("breakpoint enable moved without a trap change or arm");
endmodule
`default_nettype wire

// *** tb/ebd_target_model.sv ***
// target board bus model answering visible cycles with its acknowledge
`default_nettype none
module ebd_target_model (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // target bus
   input wire logic tgt_cycle_valid,
   input wire logic transfer_ack_oe_n,
   input wire logic [1:0] delay,
   output logic ack_n
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         ack_n <= 1'b1;
      end else if (tgt_cycle_valid && transfer_ack_oe_n) begin
         // answer after the commanded wait states, hold until the cycle ends
         if (cnt >= delay) begin
            ack_n <= 1'b0;
         end
         cnt <= cnt + 1;
      end else begin
         // released line sits at its pull-up level
         cnt <= 0;
         ack_n <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** tb/ebd_control_tb.sv ***
// self-checking bench for the emulator bus debug control block
`default_nettype none
module ebd_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ebd_pkg::*;
   logic clk = 0, rstn = 0, drive_bg, ilock, rom_brk, arm, strobe, wr, bg, rom, emul;
   logic [3:0] cs_cfg, trap;
   logic [1:0] qual, delay;
   logic [63:0] base_regs, opt_regs;
   logic [23:0] addr;
   logic cpu_ack_n, ack_out, ack_oe_n, tgt_valid, emem_we, brk, bk_en, trc, mism, tgt_ack_n, ack_wire;
   logic [7:0] vec;
   int errors = 0, compares = 0, seed = 93;
   always #20 clk = ~clk;
   assign ack_wire = ack_oe_n ? tgt_ack_n : ack_out;
   ebd_control #(.CS_N(4)) uut (.clk(clk), .rstn(rstn), .drive_bg_cycles(drive_bg), .interlock_en(ilock),
      .rom_break_en(rom_brk), .cs_src_cfg_internal(cs_cfg), .trap_num_cfg(trap), .sw_bkpt_arm(arm),
      .trace_qual(qual), .chip_select_base_regs(base_regs), .chip_select_option_regs(opt_regs),
      .cpu_strobe(strobe), .cpu_addr(addr), .cpu_write(wr), .in_background(bg), .map_rom(rom),
      .map_emul(emul), .cpu_transfer_ack_n(cpu_ack_n), .transfer_ack_n_in(ack_wire),
      .transfer_ack_n_out(ack_out), .transfer_ack_oe_n(ack_oe_n), .tgt_cycle_valid(tgt_valid),
      .emem_write_en(emem_we), .break_req(brk), .sw_bkpt_enable(bk_en), .sw_bkpt_vector(vec),
      .trace_record(trc), .cs_src_mismatch(mism));
   ebd_target_model tgt (.clk(clk), .rstn(rstn), .tgt_cycle_valid(tgt_valid),
      .transfer_ack_oe_n(ack_oe_n), .delay(delay), .ack_n(tgt_ack_n));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   // bit 4 flags a matching select, low bits give its index
   function automatic logic [4:0] hit_sel(input logic [23:0] a);
      hit_sel = 5'h00;
      for (int g = 3; g >= 0; g--)
         if (base_regs[16*g] && ((a[23:11] ^ base_regs[16*g+1 +: 13]) & opt_regs[16*g+1 +: 13]) == 13'h0000)
            hit_sel = {1'b1, 4'(g)};
   endfunction
   task automatic bus_cycle;
      logic [4:0] h;
      logic internal, wait_tgt, brk_s, trc_s, vis_s, we_s, tack_s, early;
      int n;
      h = hit_sel(addr);
      internal = h[4] && opt_regs[16*h[3:0]+14];
      wait_tgt = !(bg && !drive_bg) && (!emul || ilock);
      {brk_s, trc_s, vis_s, we_s, tack_s, early} = 6'h00;
      strobe = 1'b1;
      for (n = 1; n <= 40; n++) begin
         step();
         brk_s |= brk;
         trc_s |= trc;
         vis_s |= tgt_valid;
         we_s |= emem_we;
         if (n == 1) chk("src mismatch", mism, h[4] && (cs_cfg[h[3:0]] != opt_regs[16*h[3:0]+14]));
         if (!cpu_ack_n && wait_tgt && !tack_s) early = 1'b1;
         tack_s |= !ack_wire;
         if (!cpu_ack_n || !ack_oe_n) break;
      end
      if (n > 40) begin
         chk("ack timeout", 8'h00, 8'h01);
         final_report();
      end
      repeat (2) begin
         step();
         brk_s |= brk;
         trc_s |= trc;
      end
      chk("ack route", {ack_oe_n, cpu_ack_n}, internal ? 8'h01 : 8'h02);
      if (internal) chk("target ack", ack_wire, 0);
      if (!internal && !wait_tgt) chk("latency", n[7:0], 8'(1 + EMU_ACK_CYCLES));
      if (!internal && wait_tgt) chk("interlock", early, 0);
      chk("break", brk_s, rom_brk && rom && wr && !bg);
      chk("emem write", we_s, wr && !(emul && rom));
      if (bg && !drive_bg) chk("idle bus", vis_s, 0);
      else chk("target cycle", vis_s, 1);
      chk("trace", trc_s, bg ? qual != EBD_TRQ_FOREGROUND : qual != EBD_TRQ_BACKGROUND);
      strobe = 1'b0;
      step();
      step();
      chk("ack release", {ack_oe_n, cpu_ack_n}, 8'h03);
   endtask
   task automatic run(input logic [31:0] c, input logic [7:0] hi);
      {ilock, rom_brk, drive_bg, wr, bg, rom, emul} = c[6:0];
      qual = c[8:7];
      delay = c[10:9];
      cs_cfg = c[14:11];
      for (int g = 0; g < 4; g++) begin
         // one contiguous 64 KiB block per select
         base_regs[16*g +: 16] = {2'b00, 13'((g + 1) << 5), 1'b1};
         opt_regs[16*g +: 16] = {1'b0, c[15+g], 13'h1fe0, 1'b0};
      end
      addr = {hi, c[31:16]};
      bus_cycle();
   endtask
   initial begin
      {drive_bg, ilock, rom_brk, arm, strobe, wr, bg, rom, emul} = 9'h000;
      {cs_cfg, trap, qual, delay, base_regs, opt_regs, addr} = '0;
      repeat (4) @(posedge clk);
      #1;
      chk("reset outs", {cpu_ack_n, ack_oe_n, tgt_valid, brk, bk_en, trc, emem_we}, 8'h60);
      chk("reset vec", vec, TRAP_VEC_BASE);
      rstn = 1'b1;
      step();
      $display("test reset done");
      for (int t = 1; t <= 16; t++) begin
         trap = 4'(t);
         step();
         step();
         chk("vector", vec, TRAP_VEC_BASE + 8'(trap));
         chk("bkpt off", bk_en, 0);
         arm = 1'b1;
         step();
         arm = 1'b0;
         step();
         chk("bkpt on", bk_en, 1);
      end
      // a trap change and an arm in one cycle: the change wins
      trap = 4'h5;
      arm = 1'b1;
      step();
      arm = 1'b0;
      step();
      chk("bkpt clash", bk_en, 0);
      $display("test trap done");
      run(32'h0000012b, 8'h00);
      run(32'h0000010b, 8'h00);
      run(32'h0000000c, 8'h00);
      run(32'h00010000, 8'h02);
      repeat (120) run($random(seed), 8'($unsigned($random(seed)) % 6));
      $display("test cycles done");
      final_report();
   end
endmodule
`default_nettype wire
